// File: pwm_out_pkg.sv
// package: register map, field layout, reset values and carrier types of the pwm output stage
package pwm_out_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] FAULT_CONFIG_OFS   = 8'h00;
	localparam logic [7:0] OUT_CTRL0_OFS      = 8'h04;
	localparam logic [7:0] OUT_CTRL1_OFS      = 8'h08;
	localparam logic [7:0] TRIG_CMP_OFS       = 8'h0C;
	localparam logic [7:0] PERIOD_BUF_OFS     = 8'h10;
	localparam logic [7:0] DUTY_BUF_OFS       = 8'h14;
	localparam logic [7:0] STATUS_OFS         = 8'h20;

	// ==========================================================
	// field positions
	localparam int FAULT_ENABLE_BIT      = 0;
	localparam int FAULT_MODE_BIT        = 1;
	localparam int FAULT_STATUS_BIT      = 2;
	localparam int BRK_FAULT_EN_BIT      = 7;
	localparam int PAIR_EN_LSB           = 4;
	localparam int UPDATE_LOCKOUT_BIT    = 1;
	localparam int TRIG_DIR_BIT          = 3;
	localparam int TRIG_POST_LSB         = 4;

	// ==========================================================
	// reset values
	localparam logic [2:0]  PAIR_EN_RST_OFF  = 3'h0;
	localparam logic [2:0]  PAIR_EN_RST_ON   = 3'h4;
	localparam logic [15:0] WORD_RST         = 16'h0000;
	localparam logic [3:0]  POST_RST         = 4'h0;

	// ==========================================================
	// carrier types
	typedef struct packed {
		logic brk_fault_enable;
		logic fault_mode_select;
		logic fault_enable;
	} fault_cfg_s;

	typedef struct packed {
		logic [3:0] trigger_postscale;
		logic       trigger_direction;
		logic       update_lockout;
	} out_ctrl1_s;

	typedef struct packed {
		logic [15:0] count;
		logic        count_down;
		logic        updown_mode;
		logic        period_start;
	} timebase_s;

	typedef enum logic [0:0] {
		FLT_RUN  = 1'b0,
		FLT_HOLD = 1'b1
	} fault_state_e;

endpackage

// File: pwm_output_fault_trigger.sv
// pwm output stage: polarity, pin ownership, fault handling, update lockout, event trigger
// Summary of operation
// [RL1] odd high-side outputs active-high when high polarity is 1, else active-low
// [RL2] even low-side outputs active-high when low polarity set, else active-low
// [RL3] every level, fault or override included, passes through polarity
// [RL4] default polarity settings give active-high pins
// [RL5] pair is general I/O unless enabled; enabled pair ignores latch and direction
// [RL6] unprogrammed ownership setting: reset clears all pair enables
// [RL7] ownership programmed low: reset loads pair enable field with 100
// [RL8] fault input acts only while fault enable bit 0 is set
// [RL9] fault input active-low; enabled fault forces outputs inactive in hardware
// [RL10] latched mode: inactive until input high and status cleared, resume next period
// [RL11] cycle mode: inactive while input low, resume next period, status auto clears
// [RL12] fault status bit 2 sets on fault, reads 0 without fault
// [RL13] bit 7 set makes a debugger breakpoint act as a fault
// [RL14] lockout set blocks buffer transfer; clearing loads all buffers together
// [RL15] software sets lockout, writes duty and period buffers, then clears it
// [RL16] trigger fires when time base equals 16-bit compare value
// [RL17] up/down mode: direction bit picks up or down phase; else ignored
// [RL18] no trigger while compare value is zero
// [RL19] trigger pulses always produced with no enable, sent to converter
// [RL20] trigger passes a four-bit postscaler, ratios 1:1 to 1:16
// [RL21] postscaler cleared on reset and on any compare byte write
// [RL22] each trigger is a one-clock pulse
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/100ps

module pwm_output_fault_trigger #(
	parameter int NUM_PAIRS = 3,
	parameter int NUM_DUTY  = 3
) (
	input  wire logic                           i_clk,
	input  wire logic                           i_sys_rst,
	input  wire logic [7:0]                     i_wb_adr,
	input  wire logic [31:0]                    i_wb_dat,
	input  wire logic [3:0]                     i_wb_sel,
	input  wire logic                           i_wb_we,
	input  wire logic                           i_wb_cyc,
	input  wire logic                           i_wb_stb,
	output logic      [31:0]                    o_wb_dat,
	output logic                                o_wb_ack,
	input  wire logic                           i_high_side_polarity,
	input  wire logic                           i_low_side_polarity,
	input  wire logic                           i_reset_pin_ownership_cfg,
	input  wire logic [2*NUM_PAIRS-1:0]         i_pwm_level,
	input  wire logic [2*NUM_PAIRS-1:0]         i_port_latch,
	input  wire logic [2*NUM_PAIRS-1:0]         i_pin_direction_reg,
	input  wire logic                           i_fault_input_n,
	input  wire logic                           i_breakpoint_hit,
	input  wire pwm_out_pkg::timebase_s         i_timebase,
	output logic      [2*NUM_PAIRS-1:0]         o_pwm_pin,
	output logic      [2*NUM_PAIRS-1:0]         o_pwm_oe,
	output logic      [15:0]                    o_period_value,
	output logic      [NUM_DUTY*16-1:0]         o_duty_cycle_value,
	output logic                                o_trigger_pulse,
	output logic                                o_fault_active
);
	import pwm_out_pkg::*;

	// ==========================================================
	// elaboration checks
	if (NUM_PAIRS != 3) begin : g_bad_pairs
		$error("NUM_PAIRS must be 3: the pair enable code covers three pairs");
	end
	if (NUM_DUTY < 1 || NUM_DUTY > 3) begin : g_bad_duty
		$error("NUM_DUTY must lie between 1 and 3");
	end

	localparam int NPIN = 2 * NUM_PAIRS;

	// ==========================================================
	// wishbone slave
	logic        req;
	logic        wr_go;
	logic [31:0] rd_nxt;
	logic [15:0] wr_word;

	assign req     = i_wb_cyc & i_wb_stb;
	// writes land on the edge where the master sees ack
	assign wr_go   = req & i_wb_we & o_wb_ack;
	assign wr_word = {i_wb_sel[1] ? i_wb_dat[15:8] : 8'h00, i_wb_dat[7:0]};

	fault_cfg_s      fcfg_r;
	logic            status_r;
	logic [2:0]      pair_en_r;
	out_ctrl1_s      ctrl1_r;
	logic [15:0]     cmp_r;
	logic [15:0]     period_buf_r;
	logic [15:0]     period_act_r;
	logic [15:0]     duty_buf_r [NUM_DUTY];
	fault_state_e    fstate_r;
	logic            fault_cond;
	logic            cmp_wr;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wb_ack <= 1'b0;
		end else begin
			o_wb_ack <= req & ~o_wb_ack;
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (i_wb_adr)
			FAULT_CONFIG_OFS: rd_nxt[7:0] = {fcfg_r.brk_fault_enable, 4'h0, status_r,
				fcfg_r.fault_mode_select, fcfg_r.fault_enable};
			OUT_CTRL0_OFS:    rd_nxt[PAIR_EN_LSB +: 3] = pair_en_r;
			OUT_CTRL1_OFS:    rd_nxt[7:0] = {ctrl1_r.trigger_postscale,
				ctrl1_r.trigger_direction, 1'b0, ctrl1_r.update_lockout, 1'b0};
			TRIG_CMP_OFS:     rd_nxt[15:0] = cmp_r;
			PERIOD_BUF_OFS:   rd_nxt[15:0] = period_buf_r;
			STATUS_OFS:       rd_nxt[1:0] = {fstate_r == FLT_HOLD, fault_cond};
			default: begin
				for (int d = 0; d < NUM_DUTY; d++) begin
					if (i_wb_adr == DUTY_BUF_OFS + 8'(4 * d)) begin
						rd_nxt[15:0] = duty_buf_r[d];
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wb_dat <= 32'h0000_0000;
		end else if (req & ~o_wb_ack) begin
			o_wb_dat <= rd_nxt;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fcfg_r <= '0;
		end else if (wr_go && i_wb_sel[0] && i_wb_adr == FAULT_CONFIG_OFS) begin
			fcfg_r.fault_enable      <= i_wb_dat[FAULT_ENABLE_BIT];
			fcfg_r.fault_mode_select <= i_wb_dat[FAULT_MODE_BIT];
			fcfg_r.brk_fault_enable  <= i_wb_dat[BRK_FAULT_EN_BIT];
		end
	end

	// the reset value is a strap sampled while the synchronous reset is held
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			pair_en_r <= i_reset_pin_ownership_cfg ? PAIR_EN_RST_OFF  // [RL6]
				: PAIR_EN_RST_ON;  // [RL7]
		end else if (wr_go && i_wb_sel[0] && i_wb_adr == OUT_CTRL0_OFS) begin
			pair_en_r <= i_wb_dat[PAIR_EN_LSB +: 3];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl1_r <= '0;
		end else if (wr_go && i_wb_sel[0] && i_wb_adr == OUT_CTRL1_OFS) begin
			ctrl1_r.trigger_postscale <= i_wb_dat[TRIG_POST_LSB +: 4];
			ctrl1_r.trigger_direction <= i_wb_dat[TRIG_DIR_BIT];
			ctrl1_r.update_lockout    <= i_wb_dat[UPDATE_LOCKOUT_BIT];
		end
	end

	assign cmp_wr = wr_go && (i_wb_sel[1:0] != 2'b00) && i_wb_adr == TRIG_CMP_OFS;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cmp_r <= WORD_RST;
		end else if (cmp_wr) begin
			if (i_wb_sel[0]) begin
				cmp_r[7:0] <= i_wb_dat[7:0];
			end
			if (i_wb_sel[1]) begin
				cmp_r[15:8] <= i_wb_dat[15:8];
			end
		end
	end

	// ==========================================================
	// double buffered period and duty values
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			period_buf_r <= WORD_RST;
		end else if (wr_go && i_wb_adr == PERIOD_BUF_OFS) begin
			if (i_wb_sel[0]) begin
				period_buf_r[7:0] <= wr_word[7:0];
			end
			if (i_wb_sel[1]) begin
				period_buf_r[15:8] <= wr_word[15:8];
			end
		end
	end

	// transfer happens every cycle the lockout is clear, so all values move as one
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			period_act_r <= WORD_RST;
		end else if (!ctrl1_r.update_lockout) begin
			period_act_r <= period_buf_r;  // [RL14]
		end
	end

	assign o_period_value = period_act_r;

	for (genvar d = 0; d < NUM_DUTY; d++) begin : g_duty
		localparam logic [7:0] OFS = DUTY_BUF_OFS + 8'(4 * d);
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				duty_buf_r[d] <= WORD_RST;
			end else if (wr_go && i_wb_adr == OFS) begin
				if (i_wb_sel[0]) begin
					duty_buf_r[d][7:0] <= wr_word[7:0];
				end
				if (i_wb_sel[1]) begin
					duty_buf_r[d][15:8] <= wr_word[15:8];
				end
			end
		end
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				o_duty_cycle_value[d*16 +: 16] <= WORD_RST;
			end else if (!ctrl1_r.update_lockout) begin
				o_duty_cycle_value[d*16 +: 16] <= duty_buf_r[d];  // [RL14]
			end
		end
	end

	// ==========================================================
	// fault handling
	assign fault_cond = (fcfg_r.fault_enable & ~i_fault_input_n)  // [RL8] [RL9]
		| (fcfg_r.brk_fault_enable & i_breakpoint_hit);  // [RL13]

	logic sw_status_clr;

	assign sw_status_clr = wr_go && i_wb_sel[0] && i_wb_adr == FAULT_CONFIG_OFS
		&& !i_wb_dat[FAULT_STATUS_BIT] && !fcfg_r.fault_mode_select;

	// a new fault in the cycle of a clear keeps the flag set
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			status_r <= 1'b0;
		end else if (fault_cond) begin
			status_r <= 1'b1;  // [RL12]
		end else if (sw_status_clr) begin
			status_r <= 1'b0;  // [RL10]
		end else if (fcfg_r.fault_mode_select && i_timebase.period_start) begin
			status_r <= 1'b0;  // [RL11]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fstate_r <= FLT_RUN;
		end else begin
			unique case (fstate_r)
				FLT_RUN: begin
					if (fault_cond) begin
						fstate_r <= FLT_HOLD;  // [RL9]
					end
				end
				FLT_HOLD: begin
					if (i_timebase.period_start && !fault_cond
						&& (fcfg_r.fault_mode_select || !status_r)) begin
						fstate_r <= FLT_RUN;  // [RL10] [RL11]
					end
				end
			endcase
		end
	end

	// ==========================================================
	// pin drive with polarity and ownership
	logic             force_off;
	logic [NPIN-1:0]  pol;
	logic [NPIN-1:0]  pair_own;

	// the current fault is used as well so the pins go inactive one cycle earlier, on the edge that enters the hold state
	assign force_off = fault_cond || fstate_r == FLT_HOLD;  // [RL9]

	for (genvar p = 0; p < NPIN; p++) begin : g_pin
		// unprogrammed polarity settings read 1, giving active-high pins
		assign pol[p] = (p % 2 == 1) ? i_high_side_polarity  // [RL1] [RL4]
			: i_low_side_polarity;  // [RL2]
		// code n enables the first n pairs, 3 and above enable all
		assign pair_own[p] = pair_en_r > 3'(p / 2);
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				o_pwm_pin[p] <= 1'b0;
				o_pwm_oe[p]  <= 1'b0;
			end else if (pair_own[p]) begin
				o_pwm_pin[p] <= (i_pwm_level[p] & ~force_off) ^ ~pol[p];  // [RL3]
				o_pwm_oe[p]  <= 1'b1;  // [RL5]
			end else begin
				o_pwm_pin[p] <= i_port_latch[p];  // [RL5]
				o_pwm_oe[p]  <= ~i_pin_direction_reg[p];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_fault_active <= 1'b0;
		end else begin
			o_fault_active <= force_off;
		end
	end

	// ==========================================================
	// special event trigger
	logic       match;
	logic       match_prev_r;
	logic [3:0] post_cnt_r;
	logic       dir_ok;

	assign dir_ok = !i_timebase.updown_mode
		|| (i_timebase.count_down == ctrl1_r.trigger_direction);  // [RL17]
	assign match  = i_timebase.count == cmp_r  // [RL16]
		&& cmp_r != WORD_RST && dir_ok;  // [RL18]

	// a prescaled time base dwells on one count; only the first cycle counts
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			match_prev_r <= 1'b0;
		end else begin
			match_prev_r <= match;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || cmp_wr) begin
			post_cnt_r      <= POST_RST;  // [RL21]
			o_trigger_pulse <= 1'b0;
		end else if (match && !match_prev_r) begin
			if (post_cnt_r == ctrl1_r.trigger_postscale) begin
				post_cnt_r      <= POST_RST;
				o_trigger_pulse <= 1'b1;  // [RL19] [RL20]
			end else begin
				post_cnt_r      <= post_cnt_r + 4'h1;
				o_trigger_pulse <= 1'b0;
			end
		end else begin
			o_trigger_pulse <= 1'b0;  // [RL22]
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	a_trig_one_cycle: assert property (o_trigger_pulse |=> !o_trigger_pulse) // [RL22]
		else $error("trigger pulse longer than one cycle");
	a_trig_nonzero_cmp: assert property (o_trigger_pulse |-> $past(cmp_r) != 16'h0000) // [RL18]
		else $error("trigger with zero compare value");
	a_trig_on_match: assert property (o_trigger_pulse |->
		$past(i_timebase.count) == $past(cmp_r)) // [RL16]
		else $error("trigger without time base match");
	a_lockout_holds: assert property (ctrl1_r.update_lockout |=> $stable(period_act_r)) // [RL14]
		else $error("period changed under lockout");
	a_unlock_loads: assert property (!ctrl1_r.update_lockout |=>
		period_act_r == $past(period_buf_r)) // [RL14]
		else $error("buffer not loaded while unlocked");
	a_fault_sets_flag: assert property (fault_cond |=> status_r && fstate_r == FLT_HOLD) // [RL12]
		else $error("fault did not set status and hold");
	a_fault_pins_off: assert property (fault_cond |=>
		((o_pwm_pin ^ ~$past(pol)) & $past(pair_own)) == '0) // [RL9]
		else $error("owned pin active during fault");
	a_fault_ignored: assert property (!fcfg_r.fault_enable && !fcfg_r.brk_fault_enable
		&& fstate_r == FLT_RUN |=> fstate_r == FLT_RUN) // [RL8]
		else $error("fault taken while disabled");
	a_latched_stays: assert property (fstate_r == FLT_HOLD && !fcfg_r.fault_mode_select
		&& status_r && !sw_status_clr |=> fstate_r == FLT_HOLD) // [RL10]
		else $error("latched fault released without clear");
	a_cbc_auto_clear: assert property (fcfg_r.fault_mode_select && !fault_cond
		&& i_timebase.period_start |=> !status_r) // [RL11]
		else $error("status not cleared at period start");
	a_gpio_follow: assert property (!pair_own[0] |=>
		o_pwm_oe[0] == !$past(i_pin_direction_reg[0]) && o_pwm_pin[0] == $past(i_port_latch[0])) // [RL5]
		else $error("unowned pin not under port control");
	a_ack_drops: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack held two cycles");
	a_reset_pairs: assert property (@(posedge i_clk) disable iff (1'b0)
		i_sys_rst |=> pair_en_r == ($past(i_reset_pin_ownership_cfg) ? 3'h0 : 3'h4)) // [RL7]
		else $error("pair enable reset value wrong");

endmodule

// File: power_stage_model.sv
// power stage model: gate drive levels and the overcurrent trip line
`timescale 1ns/100ps

module power_stage_model (
	input  wire logic [5:0] i_pwm_pin,
	input  wire logic [5:0] i_pwm_oe,
	input  wire logic       i_trip,
	output logic      [5:0] o_gate,
	output logic            o_fault_n
);
	// ==========================================================
	// gate inputs
	// an undriven gate input sits on its pull-down, so a floating pin reads as off
	assign o_gate = i_pwm_pin & i_pwm_oe;
	// open-drain trip line with pull-up: idle high, pulled low on overcurrent
	assign o_fault_n = ~i_trip;
endmodule

// File: pwm_output_fault_trigger_tb.sv
// self-checking bench: pin ownership, polarity, faults, update lockout and event trigger
`timescale 1ns/100ps

module pwm_output_fault_trigger_tb;
	import pwm_out_pkg::*;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [3:0]  sel = 4'hf;
	logic        we = 1'h0, cyc = 1'h0, stb = 1'h0, ack, trig, fact, fault_n;
	logic        hp = 1'h1, lp = 1'h1, own = 1'h1, trip = 1'h0, brk = 1'h0;
	logic [5:0]  lvl = 6'h00, latch = 6'h00, dir = 6'h3f, pin, oe, gate;
	timebase_s   tbase = '0;
	logic [31:0] wbq, rdat;
	logic [15:0] per, cv, pv;
	logic [15:0] dv [3];
	logic [47:0] duty;
	logic        trig_d = 1'h0;
	int          bad_count = 0, tests_run = 0, cycles = 0, trig_n = 0, n0 = 0;
	int          seed = 24514;

	always #20 clk = ~clk;

	pwm_output_fault_trigger i_pwm_output_fault_trigger (
		.i_clk(clk), .i_sys_rst(rst), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
		.i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(wbq), .o_wb_ack(ack),
		.i_high_side_polarity(hp), .i_low_side_polarity(lp),
		.i_reset_pin_ownership_cfg(own), .i_pwm_level(lvl), .i_port_latch(latch),
		.i_pin_direction_reg(dir), .i_fault_input_n(fault_n), .i_breakpoint_hit(brk),
		.i_timebase(tbase), .o_pwm_pin(pin), .o_pwm_oe(oe), .o_period_value(per),
		.o_duty_cycle_value(duty), .o_trigger_pulse(trig), .o_fault_active(fact)
	);

	power_stage_model i_power_stage_model (
		.i_pwm_pin(pin), .i_pwm_oe(oe), .i_trip(trip), .o_gate(gate), .o_fault_n(fault_n)
	);

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (trig === 1'h1) trig_n++;
		if (trig === 1'h1) chk(32'(trig_d), 32'h0000_0000);
		trig_d <= trig;
		// generous ceiling: the whole sequence needs a few hundred cycles
		if (cycles == 30000) begin
			bad_count++;
			end_of_test();
		end
	end

	// waits for ack as long as it takes; only the cycle ceiling ends a hung transfer
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'h1);
		rdat = wbq;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0000_0000);
		chk(rdat, e);
	endtask

	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic pstart;
		@(posedge clk) tbase.period_start <= 1'h1;
		@(posedge clk) tbase.period_start <= 1'h0;
	endtask

	function automatic logic [5:0] act(input logic [5:0] l);
		for (int p = 0; p < 6; p++) act[p] = ((p % 2 == 1) ? hp : lp) ? l[p] : ~l[p];
	endfunction

	// enabled pins show the polarised level, the rest follow latch and direction
	task automatic chk_pins(input logic [5:0] en, input logic [5:0] l);
		logic [5:0] eo, ep;
		eo = en | ~dir;
		ep = ((act(l) & en) | (latch & ~en)) & eo;
		chk(32'(oe), 32'(eo));
		chk(32'(pin & eo), 32'(ep));
		chk(32'(gate), 32'(ep));
	endtask

	task automatic tset(input logic [7:0] c1);
		wr(OUT_CTRL1_OFS, 32'(c1));
		wr(TRIG_CMP_OFS, 32'(cv));
	endtask

	task automatic match(input int n, input logic dn, input logic ud);
		repeat (n) begin
			@(posedge clk);
			tbase.count <= cv - 16'h0001;
			tbase.count_down <= dn;
			tbase.updown_mode <= ud;
			@(posedge clk);
			tbase.count <= cv;
			repeat (2) @(posedge clk);
			tbase.count <= cv + 16'h0001;
		end
		repeat (3) @(posedge clk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(FAULT_CONFIG_OFS, 32'h0000_0000);
		rd(OUT_CTRL0_OFS, 32'h0000_0000);
		rd(8'h3c, 32'h0000_0000);
		for (int k = 0; k < 4; k++) begin
			wr(OUT_CTRL0_OFS, 32'(k) << PAIR_EN_LSB);
			repeat (6) begin
				@(posedge clk);
				lvl <= 6'($random(seed));
				latch <= 6'($random(seed));
				dir <= 6'($random(seed));
				hp <= 1'($random(seed));
				lp <= 1'($random(seed));
				settle();
				chk_pins(6'((1 << (2 * k)) - 1), lvl);
			end
		end
		@(posedge clk);
		hp <= 1'h1;
		lp <= 1'h1;
		settle();
		chk_pins(6'h3f, lvl);
		// second reset with the ownership setting programmed
		@(posedge clk);
		own <= 1'h0;
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rd(OUT_CTRL0_OFS, 32'h0000_0040);
		chk_pins(6'h3f, lvl);
		// ==========================================================
		// faults: mixed polarity so the inactive level is not all zero
		@(posedge clk);
		lvl <= 6'h2d;
		hp <= 1'h0;
		trip <= 1'h1;
		settle();
		chk_pins(6'h3f, lvl);
		wr(FAULT_CONFIG_OFS, 32'h0000_0001);
		settle();
		chk_pins(6'h3f, 6'h00);
		chk(32'(fact), 32'h0000_0001);
		rd(FAULT_CONFIG_OFS, 32'h0000_0005);
		rd(STATUS_OFS, 32'h0000_0003);
		@(posedge clk) trip <= 1'h0;
		pstart();
		settle();
		chk_pins(6'h3f, 6'h00);
		rd(STATUS_OFS, 32'h0000_0002);
		wr(FAULT_CONFIG_OFS, 32'h0000_0001);
		settle();
		chk_pins(6'h3f, 6'h00);
		pstart();
		settle();
		chk_pins(6'h3f, lvl);
		chk(32'(fact), 32'h0000_0000);
		rd(FAULT_CONFIG_OFS, 32'h0000_0001);
		wr(FAULT_CONFIG_OFS, 32'h0000_0003);
		@(posedge clk) trip <= 1'h1;
		settle();
		chk_pins(6'h3f, 6'h00);
		rd(FAULT_CONFIG_OFS, 32'h0000_0007);
		@(posedge clk) trip <= 1'h0;
		settle();
		chk_pins(6'h3f, 6'h00);
		pstart();
		settle();
		chk_pins(6'h3f, lvl);
		rd(FAULT_CONFIG_OFS, 32'h0000_0003);
		wr(FAULT_CONFIG_OFS, 32'h0000_0000);
		@(posedge clk) brk <= 1'h1;
		settle();
		chk_pins(6'h3f, lvl);
		wr(FAULT_CONFIG_OFS, 32'h0000_0082);
		settle();
		chk_pins(6'h3f, 6'h00);
		@(posedge clk) brk <= 1'h0;
		pstart();
		settle();
		chk_pins(6'h3f, lvl);
		// ==========================================================
		// update lockout
		wr(PERIOD_BUF_OFS, 32'h0000_1234);
		settle();
		chk(32'(per), 32'h0000_1234);
		wr(OUT_CTRL1_OFS, 32'h0000_0002);
		pv = 16'($random(seed));
		wr(PERIOD_BUF_OFS, 32'(pv));
		for (int d = 0; d < 3; d++) begin
			dv[d] = 16'($random(seed));
			wr(DUTY_BUF_OFS + 8'(4 * d), 32'(dv[d]));
		end
		settle();
		chk(32'(per), 32'h0000_1234);
		for (int d = 0; d < 3; d++) chk(32'(duty[16*d+:16]), 32'h0000_0000);
		wr(OUT_CTRL1_OFS, 32'h0000_0000);
		settle();
		chk(32'(per), 32'(pv));
		for (int d = 0; d < 3; d++) chk(32'(duty[16*d+:16]), 32'(dv[d]));
		// ==========================================================
		// event trigger: every mode and direction combination
		cv = 16'($random(seed)) | 16'h0100;
		for (int i = 0; i < 8; i++) begin
			tset(8'(i[0]) << TRIG_DIR_BIT);
			n0 = trig_n;
			match(1, i[1], i[2]);
			chk(32'(trig_n - n0), (!i[2] || i[1] == i[0]) ? 32'h1 : 32'h0);
		end
		cv = 16'h0000;
		tset(8'h00);
		n0 = trig_n;
		match(2, 1'h0, 1'h0);
		chk(32'(trig_n - n0), 32'h0000_0000);
		cv = 16'h0a5c;
		tset(8'h20);
		n0 = trig_n;
		match(6, 1'h0, 1'h0);
		chk(32'(trig_n - n0), 32'h0000_0002);
		tset(8'hf0);
		n0 = trig_n;
		match(16, 1'h0, 1'h0);
		chk(32'(trig_n - n0), 32'h0000_0001);
		tset(8'h20);
		n0 = trig_n;
		match(2, 1'h0, 1'h0);
		wr(TRIG_CMP_OFS, 32'(cv));
		match(2, 1'h0, 1'h0);
		chk(32'(trig_n - n0), 32'h0000_0000);
		match(1, 1'h0, 1'h0);
		chk(32'(trig_n - n0), 32'h0000_0001);
		// low byte alone: the high byte of the compare value must survive
		@(posedge clk) sel <= 4'h1;
		wr(TRIG_CMP_OFS, 32'h0000_ffff);
		sel <= 4'hf;
		rd(TRIG_CMP_OFS, 32'h0000_0aff);
		end_of_test();
	end
endmodule
